// [mdlc_top.v]
// display loop control of a battery heat/cooling meter, with an apb register slave
//
// Overview of operation
// R1: key press wakes a dark display
// R2: display off eight minutes after last press
// R3: holds of 5, 7, 9 s change loops
// R4: 5 s service, 7 s setup, 9 s verification
// R5: transport state opens customer, service, setup loops
// R6: country setting may block setup in transport
// R7: first integration blocks setup unless seal shorted
// R8: blocked setup opens only while contacts shorted
// R9: verification loop needs broken verification seal
// R10: setup loop edits parameters via key
// R11: index shown except in customer loop
// R12: service loop fixed, covers all readings
// R13: selection code picks customer loop readings
// R14: seven or eight digits plus status symbols
// R15: faulty temperature sensor dashes its readings
// R16: reverse flow keeps flow reading valid
// R17: flow failure dashes flow and power
// R18: faults stop counting in affected totals
// R19: faults raise info codes, info symbol flashes
// R20: confirmation symbol after value saved
// R21: heartbeat while meter and display active
// R22: energy totals always shown positive
// R23: delta and power negative when cooling
// R24: service short press next, long toggles secondary
`include "mdlc_regs.vh"

module mdlc_top #(
    parameter TICK_CYCLES = `MDLC_TICK_CYCLES,
    parameter OFF_TIMEOUT_MS = `MDLC_OFF_TIMEOUT_MS,
    parameter HOLD_SERV_MS = `MDLC_HOLD_SERV_MS,
    parameter HOLD_CONF_MS = `MDLC_HOLD_CONF_MS,
    parameter HOLD_VERI_MS = `MDLC_HOLD_VERI_MS
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // front key and seal contacts
    input wire key_in,
    input wire setup_seal_short,
    input wire verify_seal_broken,
    // meter state
    input wire first_integration,
    input wire meter_active,
    input wire cooling_mode,
    input wire inlet_temp_fault,
    input wire outlet_temp_fault,
    input wire flow_fault,
    input wire reverse_flow_fault,
    // display control
    output reg display_on,
    output reg [3:0] loop_sel,
    output reg [5:0] reading_idx,
    output reg [3:0] sub_idx,
    output reg secondary,
    output reg show_index,
    output reg [7:0] edit_value,
    // symbols and signs
    output reg digits8,
    output reg radio_sym,
    output reg outlet_sym,
    output reg info_sym,
    output reg ok_sym,
    output reg heartbeat_seg,
    output reg delta_neg,
    output reg power_neg,
    // dash lines on current values
    output reg dash_inlet,
    output reg dash_outlet,
    output reg dash_delta,
    output reg dash_flow,
    output reg dash_power,
    // accumulation enables
    output reg heat_energy_total_en,
    output reg cooling_energy_total_en,
    output reg inlet_volume_temperature_product_en,
    output reg outlet_volume_temperature_product_en,
    output reg flow_volume_total_en
);

localparam [31:0] LONG_MS = `MDLC_LONG_PRESS_MS;
localparam [31:0] FLASH_MS = `MDLC_FLASH_HALF_MS;

reg [17:0] tick_cnt_reg;
reg tick, key_d_reg, flash_reg, consumed_reg, integ_done_reg, edit_dirty_reg, allowed;
reg [13:0] hold_ms_reg;
reg [18:0] idle_ms_reg;
reg [9:0] flash_ms_reg;
reg [`MDLC_CTRL_W-1:0] ctrl_reg;
reg [`MDLC_SEL_W-1:0] sel_reg;
reg [`MDLC_INFO_W-1:0] info_reg;
reg [`MDLC_PARAM_W-1:0] param_reg;
reg [3:0] target, loop_next;
wire press, release_ev, conf_open, wr_en, rd_setup;
wire [`MDLC_INFO_W-1:0] info_set;

// next enabled customer reading after the current one, wrapping
function [3:0] mdlc_next_sel;
    input [`MDLC_SEL_W-1:0] code;
    input [3:0] cur;
    integer i;
    integer j;
    reg done;
    begin
        mdlc_next_sel = cur;
        done = 1'b0;
        for (i = 1; i <= `MDLC_SEL_W; i = i + 1) begin
            j = cur + i;
            if (j >= `MDLC_SEL_W)
                j = j - `MDLC_SEL_W;
            if (!done && code[j]) begin
                mdlc_next_sel = j[3:0];
                done = 1'b1;
            end
        end
    end
endfunction

// fixed count of secondary readings behind each service primary reading
function [3:0] mdlc_sub_count;
    input [5:0] prim;
    begin
        case (prim)
            6'h00, 6'h01, 6'h02: mdlc_sub_count = 4'h5;
            6'h03: mdlc_sub_count = 4'h1;
            6'h04, 6'h05, 6'h06: mdlc_sub_count = 4'h2;
            6'h07, 6'h08: mdlc_sub_count = 4'h8;
            default: mdlc_sub_count = 4'h0;
        endcase
    end
endfunction

// key edges; inputs are synchronous to sys_clk
assign press = key_in & ~key_d_reg;
assign release_ev = ~key_in & key_d_reg;

// setup loop gating
assign conf_open = (~integ_done_reg & ~ctrl_reg[`MDLC_CTRL_CFG_BLOCK]) // [R5] [R6] [R7]
    | setup_seal_short; // [R8]

// apb strobes, zero wait
assign wr_en = psel & penable & pwrite;
assign rd_setup = psel & ~penable & ~pwrite;
assign pready = 1'b1;
assign pslverr = psel & penable & (paddr != `MDLC_CTRL_OFS) & (paddr != `MDLC_SEL_OFS)
    & (paddr != `MDLC_STAT_OFS) & (paddr != `MDLC_INFO_OFS) & (paddr != `MDLC_PARAM_OFS);

// every fault, reverse flow included, raises an info code
assign info_set = {reverse_flow_fault, flow_fault, outlet_temp_fault, inlet_temp_fault}; // [R19]

// millisecond tick divider
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        tick_cnt_reg <= 18'h00000;
        tick <= 1'b0;
    end else if (tick_cnt_reg == TICK_CYCLES - 1) begin
        tick_cnt_reg <= 18'h00000;
        tick <= 1'b1;
    end else begin
        tick_cnt_reg <= tick_cnt_reg + 18'h00001;
        tick <= 1'b0;
    end
end

// flash phase for blinking symbols
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        flash_ms_reg <= 10'h000;
        flash_reg <= 1'b0;
    end else if (tick) begin
        if (flash_ms_reg == FLASH_MS[9:0] - 10'h001) begin
            flash_ms_reg <= 10'h000;
            flash_reg <= ~flash_reg;
        end else begin
            flash_ms_reg <= flash_ms_reg + 10'h001;
        end
    end
end

// software registers; hardware sets of info bits win over clears
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        ctrl_reg <= `MDLC_CTRL_RST;
        sel_reg <= `MDLC_SEL_RST;
        info_reg <= {`MDLC_INFO_W{1'b0}};
        integ_done_reg <= 1'b0;
    end else begin
        if (wr_en && paddr == `MDLC_CTRL_OFS)
            ctrl_reg <= pwdata[`MDLC_CTRL_W-1:0];
        if (wr_en && paddr == `MDLC_SEL_OFS)
            sel_reg <= pwdata[`MDLC_SEL_W-1:0]; // [R13]
        if (wr_en && paddr == `MDLC_INFO_OFS)
            info_reg <= (info_reg & ~pwdata[`MDLC_INFO_W-1:0]) | info_set; // [R19]
        else
            info_reg <= info_reg | info_set; // [R19]
        if (first_integration)
            integ_done_reg <= 1'b1; // [R7]
    end
end

// read data, loaded in setup cycle
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        prdata <= 32'h00000000;
    end else if (rd_setup) begin
        case (paddr)
            `MDLC_CTRL_OFS: prdata <= {28'h0000000, ctrl_reg};
            `MDLC_SEL_OFS: prdata <= {20'h00000, sel_reg};
            `MDLC_STAT_OFS: prdata <= {8'h00, integ_done_reg, conf_open, secondary, sub_idx,
                loop_sel, reading_idx, edit_value[5:0], display_on};
            `MDLC_INFO_OFS: prdata <= {28'h0000000, info_reg};
            `MDLC_PARAM_OFS: prdata <= {24'h000000, param_reg};
            default: prdata <= 32'h00000000;
        endcase
    end
end

// loop chosen by the length of a hold, and whether entry is granted
always @* begin
    if (hold_ms_reg >= HOLD_VERI_MS)
        target = `MDLC_LOOP_VERI; // [R3] [R4]
    else if (hold_ms_reg >= HOLD_CONF_MS)
        target = `MDLC_LOOP_CONF; // [R3] [R4]
    else
        target = `MDLC_LOOP_SERV; // [R3] [R4]
    case (target)
        `MDLC_LOOP_VERI: allowed = verify_seal_broken; // [R9]
        `MDLC_LOOP_CONF: allowed = conf_open; // [R7] [R8]
        `MDLC_LOOP_SERV: allowed = 1'b1; // [R5]
        default: allowed = 1'b0;
    endcase
    // refused or repeated selection falls back to the customer loop
    if (!allowed || target == loop_sel)
        loop_next = `MDLC_LOOP_CUST;
    else
        loop_next = target;
end

// key timing, display power and loop navigation
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        key_d_reg <= 1'b0;
        hold_ms_reg <= 14'h0000;
        idle_ms_reg <= 19'h00000;
        consumed_reg <= 1'b0;
        display_on <= 1'b0;
        loop_sel <= `MDLC_LOOP_CUST;
        reading_idx <= 6'h00;
        sub_idx <= 4'h0;
        secondary <= 1'b0;
        edit_value <= `MDLC_PARAM_RST;
        edit_dirty_reg <= 1'b0;
        param_reg <= `MDLC_PARAM_RST;
        ok_sym <= 1'b0;
    end else begin
        key_d_reg <= key_in;
        if (wr_en && paddr == `MDLC_PARAM_OFS)
            param_reg <= pwdata[`MDLC_PARAM_W-1:0];
        // hold length in ms, saturating
        if (press)
            hold_ms_reg <= 14'h0000;
        else if (tick && key_in && hold_ms_reg != 14'h3FFF)
            hold_ms_reg <= hold_ms_reg + 14'h0001;
        // idle time since last press
        if (press)
            idle_ms_reg <= 19'h00000; // [R2]
        else if (tick && display_on)
            idle_ms_reg <= idle_ms_reg + 19'h00001;
        if (press) begin
            ok_sym <= 1'b0;
            if (!display_on) begin
                display_on <= 1'b1; // [R1]
                consumed_reg <= 1'b1;
                loop_sel <= `MDLC_LOOP_CUST;
                reading_idx <= 6'h00;
                sub_idx <= 4'h0;
                secondary <= 1'b0;
            end
        end else if (display_on && tick && idle_ms_reg == OFF_TIMEOUT_MS - 1) begin
            display_on <= 1'b0; // [R2]
            ok_sym <= 1'b0;
        end else if (release_ev && consumed_reg) begin
            consumed_reg <= 1'b0;
        end else if (release_ev && display_on) begin
            if (hold_ms_reg >= HOLD_SERV_MS) begin
                loop_sel <= loop_next; // [R3]
                reading_idx <= 6'h00;
                sub_idx <= 4'h0;
                secondary <= 1'b0;
                edit_value <= param_reg;
                edit_dirty_reg <= 1'b0;
            end else if (hold_ms_reg >= LONG_MS[13:0]) begin
                case (loop_sel)
                    `MDLC_LOOP_SERV: begin
                        if (secondary) begin
                            secondary <= 1'b0; // [R24]
                            sub_idx <= 4'h0;
                        end else if (mdlc_sub_count(reading_idx) != 4'h0) begin
                            secondary <= 1'b1; // [R24]
                            sub_idx <= 4'h1;
                        end
                    end
                    `MDLC_LOOP_CONF: begin
                        if (edit_dirty_reg) begin
                            param_reg <= edit_value; // [R10]
                            edit_dirty_reg <= 1'b0;
                            ok_sym <= 1'b1; // [R20]
                        end
                    end
                    default: ;
                endcase
            end else begin
                case (loop_sel)
                    `MDLC_LOOP_CUST:
                        reading_idx <= {2'b00, mdlc_next_sel(sel_reg, reading_idx[3:0])}; // [R13]
                    `MDLC_LOOP_SERV: begin
                        if (secondary) begin
                            if (sub_idx == mdlc_sub_count(reading_idx))
                                sub_idx <= 4'h1; // [R24]
                            else
                                sub_idx <= sub_idx + 4'h1; // [R24]
                        end else if (reading_idx == `MDLC_SERV_PRIMARY - 1) begin
                            reading_idx <= 6'h00; // [R12]
                        end else begin
                            reading_idx <= reading_idx + 6'h01; // [R12] [R24]
                        end
                    end
                    `MDLC_LOOP_CONF: begin
                        edit_value <= edit_value + 8'h01; // [R10]
                        edit_dirty_reg <= 1'b1;
                    end
                    `MDLC_LOOP_VERI: begin
                        if (reading_idx == `MDLC_VERI_READINGS - 1)
                            reading_idx <= 6'h00;
                        else
                            reading_idx <= reading_idx + 6'h01;
                    end
                    default: loop_sel <= `MDLC_LOOP_CUST;
                endcase
            end
        end
    end
end

// symbols, signs, dash lines and accumulation enables
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        show_index <= 1'b0;
        digits8 <= 1'b0;
        radio_sym <= 1'b0;
        outlet_sym <= 1'b0;
        info_sym <= 1'b0;
        heartbeat_seg <= 1'b0;
        delta_neg <= 1'b0;
        power_neg <= 1'b0;
        dash_inlet <= 1'b0;
        dash_outlet <= 1'b0;
        dash_delta <= 1'b0;
        dash_flow <= 1'b0;
        dash_power <= 1'b0;
        heat_energy_total_en <= 1'b0;
        cooling_energy_total_en <= 1'b0;
        inlet_volume_temperature_product_en <= 1'b0;
        outlet_volume_temperature_product_en <= 1'b0;
        flow_volume_total_en <= 1'b0;
    end else begin
        show_index <= display_on && loop_sel != `MDLC_LOOP_CUST; // [R11]
        digits8 <= ctrl_reg[`MDLC_CTRL_DIGITS8]; // [R14]
        radio_sym <= display_on & ctrl_reg[`MDLC_CTRL_RADIO_ON]; // [R14]
        outlet_sym <= display_on & ctrl_reg[`MDLC_CTRL_OUTLET]; // [R14]
        info_sym <= display_on & (|info_reg) & flash_reg; // [R19]
        heartbeat_seg <= display_on & meter_active; // [R21]
        // only delta and power carry a sign
        delta_neg <= cooling_mode; // [R22] [R23]
        power_neg <= cooling_mode; // [R23]
        dash_inlet <= inlet_temp_fault; // [R15]
        dash_outlet <= outlet_temp_fault; // [R15]
        dash_delta <= inlet_temp_fault | outlet_temp_fault; // [R15]
        dash_flow <= flow_fault; // [R16] [R17]
        dash_power <= inlet_temp_fault | outlet_temp_fault | flow_fault; // [R15] [R17]
        heat_energy_total_en <= ~(inlet_temp_fault | outlet_temp_fault | flow_fault); // [R18]
        cooling_energy_total_en <= ~(inlet_temp_fault | outlet_temp_fault | flow_fault); // [R18]
        inlet_volume_temperature_product_en <= ~(inlet_temp_fault | flow_fault); // [R18]
        outlet_volume_temperature_product_en <= ~(outlet_temp_fault | flow_fault); // [R18]
        flow_volume_total_en <= ~flow_fault; // [R18]
    end
end

endmodule // mdlc_top

// [mdlc_regs.vh]
// register offsets, fields and timing counts
`ifndef MDLC_REGS_VH
`define MDLC_REGS_VH

// register byte offsets
`define MDLC_CTRL_OFS 8'h00
`define MDLC_SEL_OFS 8'h04
`define MDLC_STAT_OFS 8'h08
`define MDLC_INFO_OFS 8'h0C
`define MDLC_PARAM_OFS 8'h10

// control fields
`define MDLC_CTRL_CFG_BLOCK 0
`define MDLC_CTRL_DIGITS8 1
`define MDLC_CTRL_RADIO_ON 2
`define MDLC_CTRL_OUTLET 3
`define MDLC_CTRL_W 4
`define MDLC_CTRL_RST 4'h0

// display selection code and setup parameter
`define MDLC_SEL_W 12
`define MDLC_SEL_RST 12'h00F
`define MDLC_PARAM_W 8
`define MDLC_PARAM_RST 8'h00

// info code bits
`define MDLC_INFO_INLET 0
`define MDLC_INFO_OUTLET 1
`define MDLC_INFO_FLOW 2
`define MDLC_INFO_REVERSE 3
`define MDLC_INFO_W 4

// loop codes, one-hot
`define MDLC_LOOP_CUST 4'h1
`define MDLC_LOOP_SERV 4'h2
`define MDLC_LOOP_CONF 4'h4
`define MDLC_LOOP_VERI 4'h8

// timing figures in their own units
`define MDLC_CLK_PERIOD_PS 5000
`define MDLC_TICK_PERIOD_PS 1000000000
`define MDLC_OFF_TIMEOUT_MIN 8
`define MDLC_HOLD_SERV_S 5
`define MDLC_HOLD_CONF_S 7
`define MDLC_HOLD_VERI_S 9
`define MDLC_LONG_PRESS_MS 2000
`define MDLC_FLASH_HALF_MS 500

// derived counts, in clock cycles or in millisecond ticks
`define MDLC_TICK_CYCLES (`MDLC_TICK_PERIOD_PS / `MDLC_CLK_PERIOD_PS)
`define MDLC_OFF_TIMEOUT_MS (`MDLC_OFF_TIMEOUT_MIN * 60000)
`define MDLC_HOLD_SERV_MS (`MDLC_HOLD_SERV_S * 1000)
`define MDLC_HOLD_CONF_MS (`MDLC_HOLD_CONF_S * 1000)
`define MDLC_HOLD_VERI_MS (`MDLC_HOLD_VERI_S * 1000)

// reading counts per loop
`define MDLC_SERV_PRIMARY 10
`define MDLC_VERI_READINGS 8

`endif

// [mdlc_assertions.sv]
// port assertions of the display loop control, bound into its top module
module mdlc_assertions #(
    parameter TICK_CYCLES = 4,
    parameter OFF_TIMEOUT_MS = 50
) (
    // clock and reset
    input logic sys_clk,
    input logic rst_b,
    // key, seals and meter state
    input logic key_in,
    input logic setup_seal_short,
    input logic verify_seal_broken,
    input logic first_integration,
    input logic cooling_mode,
    input logic inlet_temp_fault,
    input logic outlet_temp_fault,
    input logic flow_fault,
    input logic reverse_flow_fault,
    // display state and signs
    input logic display_on,
    input logic [3:0] loop_sel,
    input logic show_index,
    input logic delta_neg,
    input logic power_neg,
    // dash lines and accumulation enables
    input logic dash_inlet,
    input logic dash_outlet,
    input logic dash_delta,
    input logic dash_flow,
    input logic dash_power,
    input logic heat_energy_total_en,
    input logic cooling_energy_total_en,
    input logic inlet_volume_temperature_product_en,
    input logic outlet_volume_temperature_product_en,
    input logic flow_volume_total_en
);
    localparam int LIM = (OFF_TIMEOUT_MS + 3) * TICK_CYCLES;
    int idle_cnt;
    logic integ_seen;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // saturating idle cycles with display lit and key up; integration seen
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_cnt <= 0;
            integ_seen <= 1'b0;
        end else begin
            if (key_in || !display_on)
                idle_cnt <= 0;
            else if (idle_cnt < LIM)
                idle_cnt <= idle_cnt + 1;
            if (first_integration)
                integ_seen <= 1'b1;
        end
    end
    property p_wake;
        $rose(key_in) && !display_on |-> ##[1:2] display_on && loop_sel == 4'h1;
    endproperty
    a_wake: assert property (p_wake) else $error("display did not wake");
    property p_timeout;
        idle_cnt == LIM |-> !display_on;
    endproperty
    a_timeout: assert property (p_timeout) else $error("display stayed on");
    property p_onehot;
        $onehot(loop_sel);
    endproperty
    a_onehot: assert property (p_onehot) else $error("loop select not one-hot");
    property p_verify;
        $rose(loop_sel[3]) |-> verify_seal_broken;
    endproperty
    a_verify: assert property (p_verify) else $error("test loop with seal intact");
    property p_setup;
        $rose(loop_sel[2]) && integ_seen |-> setup_seal_short;
    endproperty
    a_setup: assert property (p_setup) else $error("setup entered while blocked");
    property p_index;
        $stable(loop_sel) && $stable(display_on) |-> show_index == (display_on && !loop_sel[0]);
    endproperty
    a_index: assert property (p_index) else $error("index shown wrongly");
    property p_inlet;
        inlet_temp_fault |=> dash_inlet && dash_delta && dash_power && !heat_energy_total_en
            && !cooling_energy_total_en && !inlet_volume_temperature_product_en;
    endproperty
    a_inlet: assert property (p_inlet) else $error("inlet fault not handled");
    property p_outlet;
        outlet_temp_fault |=> dash_outlet && dash_delta && dash_power && !heat_energy_total_en
            && !cooling_energy_total_en && !outlet_volume_temperature_product_en;
    endproperty
    a_outlet: assert property (p_outlet) else $error("outlet fault not handled");
    property p_flow;
        flow_fault |=> dash_flow && dash_power && !flow_volume_total_en
            && !inlet_volume_temperature_product_en && !outlet_volume_temperature_product_en;
    endproperty
    a_flow: assert property (p_flow) else $error("flow fault not handled");
    property p_reverse;
        reverse_flow_fault && !flow_fault |=> !dash_flow && flow_volume_total_en;
    endproperty
    a_reverse: assert property (p_reverse) else $error("reverse flow dashed");
    property p_sign;
        1'b1 |=> delta_neg == $past(cooling_mode) && power_neg == $past(cooling_mode);
    endproperty
    a_sign: assert property (p_sign) else $error("sign not following mode");
endmodule // mdlc_assertions

bind mdlc_top mdlc_assertions #(
    .TICK_CYCLES(TICK_CYCLES),
    .OFF_TIMEOUT_MS(OFF_TIMEOUT_MS)
) u_mdlc_chk (.*);

// [mdlc_key_model.sv]
// key operator and seal contacts at the meter front
module mdlc_key_model #(
    parameter int TICK = 4
) (
    // clock
    input wire logic sys_clk,
    // key and seals
    output logic key_in,
    output logic setup_seal_short,
    output logic verify_seal_broken
);
    timeunit 1ns;
    timeprecision 1ps;
    // key up, seals intact
    initial begin
        key_in = 1'b0;
        setup_seal_short = 1'b0;
        verify_seal_broken = 1'b0;
    end
    // hold key ms ticks, then idle
    task automatic press(input int ms);
        @(posedge sys_clk) key_in <= 1'b1;
        repeat (ms * TICK) @(posedge sys_clk);
        key_in <= 1'b0;
        repeat (2 * TICK) @(posedge sys_clk);
    endtask
    // set seal contacts
    task automatic seals(input logic s, input logic v);
        @(posedge sys_clk);
        setup_seal_short <= s;
        verify_seal_broken <= v;
    endtask
endmodule // mdlc_key_model

// [mdlc_tb.sv]
// self-checking bench of the display loop control
`include "mdlc_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic err;
    logic first_integration = 1'b0, cooling_mode = 1'b0, meter_act = 1'b1;
    logic [3:0] flt = 4'h0;
    wire key_in, seal_s, seal_v;
    int error_cnt = 0, compares = 0, cyc = 0;
    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    mdlc_key_model #(.TICK(TK)) kp (.sys_clk(sys_clk), .key_in(key_in),
        .setup_seal_short(seal_s), .verify_seal_broken(seal_v));
    mdlc_top #(.TICK_CYCLES(TK), .OFF_TIMEOUT_MS(50), .HOLD_SERV_MS(10), .HOLD_CONF_MS(14),
        .HOLD_VERI_MS(18)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(), .pslverr(),
        .key_in(key_in), .setup_seal_short(seal_s), .verify_seal_broken(seal_v),
        .first_integration(first_integration), .meter_active(meter_act), .cooling_mode(cooling_mode),
        .inlet_temp_fault(flt[0]), .outlet_temp_fault(flt[1]), .flow_fault(flt[2]),
        .reverse_flow_fault(flt[3]), .display_on(), .loop_sel(), .reading_idx(), .sub_idx(),
        .secondary(), .show_index(), .edit_value(), .digits8(), .radio_sym(), .outlet_sym(),
        .info_sym(), .ok_sym(), .heartbeat_seg(), .delta_neg(), .power_neg(), .dash_inlet(),
        .dash_outlet(), .dash_delta(), .dash_flow(), .dash_power(), .heat_energy_total_en(),
        .cooling_energy_total_en(), .inlet_volume_temperature_product_en(),
        .outlet_volume_temperature_product_en(), .flow_volume_total_en());
    // verdict and end of run
    task automatic wrap_up();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // value comparison
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, waiting for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (dut.pready !== 1'b1);
        rd = dut.prdata;
        err = dut.pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // key hold followed by a loop check
    task automatic hold(input int ms, input logic [3:0] lp, input string nm);
        kp.press(ms);
        chk(nm, lp, dut.loop_sel);
    endtask
    // register access
    task automatic t_regs();
        apb(1'b0, `MDLC_SEL_OFS, 32'h0);
        chk("sel_reset", 32'h0000000F, rd);
        apb(1'b1, `MDLC_SEL_OFS, 32'h00000005);
        apb(1'b1, `MDLC_CTRL_OFS, 32'h00000002);
        apb(1'b0, `MDLC_CTRL_OFS, 32'h0);
        chk("ctrl", 32'h00000002, rd);
        chk("digits8", 32'h1, dut.digits8);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped_err", 32'h1, err);
        chk("unmapped_data", 32'h0, rd);
    endtask
    // wake, navigation and loop gating
    task automatic t_keys();
        kp.press(2);
        chk("wake", 32'h1, dut.display_on);
        chk("no_index", 32'h0, dut.show_index);
        chk("heartbeat", 32'h1, dut.heartbeat_seg);
        kp.press(2);
        chk("cust_next", 32'h2, dut.reading_idx);
        kp.press(2);
        chk("cust_wrap", 32'h0, dut.reading_idx);
        hold(11, `MDLC_LOOP_SERV, "serv");
        chk("index", 32'h1, dut.show_index);
        kp.press(2);
        chk("serv_next", 32'h1, dut.reading_idx);
        hold(15, `MDLC_LOOP_CONF, "setup");
        kp.press(2);
        chk("edit", 32'h1, dut.edit_value);
        hold(11, `MDLC_LOOP_SERV, "serv2");
        apb(1'b1, `MDLC_CTRL_OFS, 32'h00000001);
        hold(15, `MDLC_LOOP_CUST, "country");
        apb(1'b1, `MDLC_CTRL_OFS, 32'h0);
        @(posedge sys_clk) first_integration <= 1'b1;
        @(posedge sys_clk) first_integration <= 1'b0;
        hold(15, `MDLC_LOOP_CUST, "blocked");
        kp.seals(1'b1, 1'b0);
        hold(15, `MDLC_LOOP_CONF, "seal_short");
        kp.seals(1'b0, 1'b0);
        hold(19, `MDLC_LOOP_CUST, "no_test");
        kp.seals(1'b0, 1'b1);
        hold(19, `MDLC_LOOP_VERI, "test");
        kp.seals(1'b0, 1'b0);
    endtask
    // faults, info, signs
    task automatic t_faults();
        logic [4:0] d, e;
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk) flt <= i[3:0];
            repeat (2) @(posedge sys_clk);
            d = {i[0], i[1], i[0] | i[1], i[2], i[0] | i[1] | i[2]};
            e = {{2{~(i[0] | i[1] | i[2])}}, ~(i[0] | i[2]), ~(i[1] | i[2]), ~i[2]};
            chk("dash", d, {dut.dash_inlet, dut.dash_outlet, dut.dash_delta, dut.dash_flow,
                dut.dash_power});
            chk("count_en", e, {dut.heat_energy_total_en, dut.cooling_energy_total_en,
                dut.inlet_volume_temperature_product_en, dut.outlet_volume_temperature_product_en,
                dut.flow_volume_total_en});
        end
        apb(1'b0, `MDLC_INFO_OFS, 32'h0);
        chk("info_set", 32'h0000000F, rd);
        flt <= 4'h0;
        apb(1'b1, `MDLC_INFO_OFS, 32'h0000000F);
        apb(1'b0, `MDLC_INFO_OFS, 32'h0);
        chk("info_clear", 32'h0, rd);
        cooling_mode <= 1'b1;
        meter_act <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("cool_sign", 32'h3, {dut.delta_neg, dut.power_neg});
        chk("no_heartbeat", 32'h0, dut.heartbeat_seg);
        cooling_mode <= 1'b0;
        meter_act <= 1'b1;
    endtask
    // idle timeout
    task automatic t_timeout();
        kp.press(2);
        repeat (42 * TK) @(posedge sys_clk);
        chk("still_on", 32'h1, dut.display_on);
        repeat (12 * TK) @(posedge sys_clk);
        chk("off", 32'h0, dut.display_on);
        hold(2, `MDLC_LOOP_CUST, "rewake");
        chk("rewake_on", 32'h1, dut.display_on);
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_regs();
        t_keys();
        t_faults();
        t_timeout();
        wrap_up();
    end
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
endmodule // testbench
